// [logic/pbsa_pkg.sv]
// shared constants, pin bundle and burst order function for the burst sram
package pbsa_pkg;

	// array geometry
	localparam int PBSA_AW    = 16;
	localparam int PBSA_DW    = 32;
	localparam int PBSA_LANES = 4;
	localparam int PBSA_DEPTH = 65536;

	// values after reset
	localparam logic [1:0]  PBSA_CNT_RST   = 2'h0;
	localparam logic [13:0] PBSA_UPPER_RST = 14'h0;
	localparam logic [31:0] PBSA_DOUT_RST  = 32'h0;
	localparam logic [15:0] PBSA_ADDR_RST  = 16'h0;
	localparam logic        PBSA_ORDER_RST = 1'h1;

	// field positions within the address
	localparam int PBSA_LO_MSB = 1;
	localparam int PBSA_UP_LSB = 2;

	// cycles to enter or leave sleep, set by the synchroniser depth
	localparam int PBSA_SLEEP_CYC = 2;

	// control states, one-hot
	typedef enum logic [2:0] {
		PBSA_ST_IDLE   = 3'b001,
		PBSA_ST_ACTIVE = 3'b010,
		PBSA_ST_SLEEP  = 3'b100
	} pbsa_state_e;

	// synchronous control pins of the bus
	typedef struct packed {
		logic       chip_sel_pipeline_n;
		logic       chip_sel_depth_hi;
		logic       chip_sel_depth_lo_n;
		logic       proc_addr_strobe_n;
		logic       ctrl_addr_strobe_n;
		logic       burst_advance_n;
		logic       all_byte_write_n;
		logic       byte_write_gate_n;
		logic [3:0] byte_lane_write_n;
	} pbsa_ctrl_s;

	// low address bits for a beat of a burst
	function automatic logic [1:0] pbsa_burst_step(
		input logic [1:0] first,
		input logic [1:0] beat,
		input logic       interleave
	);
		if (interleave)
			return first ^ beat;
		return 2'(first + beat);
	endfunction

endpackage

// [logic/pbsa_burst_ctr.sv]
// two-bit wraparound burst address counter
`timescale 1ns/100ps
module pbsa_burst_ctr
	import pbsa_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// counter control
	input  wire logic       load,
	input  wire logic       advance,
	input  wire logic       interleave,
	input  wire logic [1:0] start,
	// current and following burst address
	output logic      [1:0] addr_lo,
	output logic      [1:0] next_lo
);
	logic [1:0] start_ff;
	logic [1:0] nxt_start;
	logic [1:0] off_ff;
	logic [1:0] nxt_off;

	// load first address, step beat offset, wrap in two bits
	always_comb
	begin
		nxt_start = start_ff;
		nxt_off   = off_ff;
		if (load)
		begin
			nxt_start = start;
			nxt_off   = PBSA_CNT_RST;
		end
		else if (advance)
			nxt_off = 2'(off_ff + 2'h1);
	end

	// counter registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			start_ff <= PBSA_CNT_RST;
			off_ff   <= PBSA_CNT_RST;
		end
		else
		begin
			start_ff <= nxt_start;
			off_ff   <= nxt_off;
		end
	end

	// burst order applied to the offset
	assign addr_lo = pbsa_burst_step(start_ff, off_ff, interleave);
	assign next_lo = pbsa_burst_step(start_ff, 2'(off_ff + 2'h1), interleave);

	// fourth advance returns to the first address
	a_burst_wrap: assert property (@(posedge clk) disable iff (rst)
		(advance && !load && off_ff == 2'h3) |=> (off_ff == 2'h0 && addr_lo == start_ff))
		else $error("burst counter did not wrap to first address");

endmodule

// [logic/pbsa_core.sv]
// synchronous access logic and array of the pipelined burst sram
//
// Notes on behaviour
// - all synchronous inputs taken at rising edge; read data leaves via output register.
// - selected only with depth select high and low select low, at address load.
// - output enable low drives data pins; high releases them as inputs.
// - first clock of a read leaving deselect keeps pins released regardless.
// - advance low at an edge steps counter to next burst address.
// - processor strobe captures address and loads two low bits into counter.
// - controller strobe likewise captures address and loads the counter.
// - both strobes low means only the processor strobe acts; with pipeline select high the controller strobe acts.
// - processor strobe ignored while pipeline select is high.
// - sleep input high parks device, contents kept; normally held low.
// - data pins captured at edge; output shows location addressed at prior edge.
// - order select low is linear, high is interleaved; held static.
// - two-bit wraparound counter keeps first address and makes the rest.
// - global write low writes all four lanes regardless of byte controls.
// - byte gate low writes only lanes with their lane write low.
// - read starts on strobe, all selects active, global and byte gate high.
// - read data appears after next edge when output enable is low.
// - deselect by select with strobe releases data pins at once.
// - processor strobe write: first cycle loads address, ignores writes and advance.
// - processor strobe write finishes at second edge using controls sampled there.
// - data pins released in any detected write cycle.
// - interleaved xors start with beat; linear adds beat modulo four.
// - controller strobe write finishes in one cycle; advance ignored.
// - sleep entry and exit take two cycles; device deselected around it.
`timescale 1ns/100ps
module pbsa_core
	import pbsa_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// synchronous bus
	input  wire logic [15:0] addr,
	input  wire pbsa_ctrl_s  ctl,
	// data pins as three signals
	input  wire logic [31:0] data_in,
	output logic      [31:0] data_out,
	output logic             data_oe,
	// asynchronous and static pins
	input  wire logic        output_drive_en_n,
	input  wire logic        sleep_req,
	input  wire logic        burst_order_sel
);
	// storage
	logic [31:0] mem_q [PBSA_DEPTH];

	// state
	pbsa_state_e state_ff;
	pbsa_state_e nxt_state;
	logic [13:0] upper_ff;
	logic [13:0] nxt_upper;
	logic [15:0] rd_addr_ff;
	logic [15:0] nxt_rd_addr;
	logic        rd_pend_ff;
	logic        nxt_rd_pend;
	logic        q_valid_ff;
	logic        nxt_q_valid;
	logic        mask_ff;
	logic        nxt_mask;
	logic [31:0] dout_ff;
	logic [31:0] nxt_dout;

	// synchronisers for asynchronous and strap pins
	logic        zz_s1_ff;
	logic        zz_s2_ff;
	logic        md_s1_ff;
	logic        md_s2_ff;

	// decode of the current edge
	logic        ce_ok;
	logic        p_take;
	logic        c_take;
	logic        load;
	logic        desel;
	logic        awake;
	logic        cont;
	logic        wr_det;
	logic        wr_en;
	logic        rd_issue;
	logic [3:0]  wr_mask;
	logic [15:0] addr_used;
	logic        ctr_adv;
	logic [1:0]  cur_lo;
	logic [1:0]  next_lo;

	// burst counter
	pbsa_burst_ctr u_ctr (
		.clk        (clk),
		.rst        (rst),
		.load       (load && ce_ok),
		.advance    (ctr_adv),
		.interleave (md_s2_ff),
		.start      (addr[PBSA_LO_MSB:0]),
		.addr_lo    (cur_lo),
		.next_lo    (next_lo)
	);

	// two-flop synchronisers for sleep and order select
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			zz_s1_ff <= 1'h0;
			zz_s2_ff <= 1'h0;
			md_s1_ff <= PBSA_ORDER_RST;
			md_s2_ff <= PBSA_ORDER_RST;
		end
		else
		begin
			zz_s1_ff <= sleep_req;
			zz_s2_ff <= zz_s1_ff;
			md_s1_ff <= burst_order_sel;
			md_s2_ff <= md_s1_ff;
		end
	end

	// strobe qualification and chip select decode
	// sleep gating follows the second synchroniser flop only, so entry and
	// exit each take two edges; the sleep state just tracks it
	always_comb
	begin
		awake  = !zz_s2_ff;
		ce_ok  = !ctl.chip_sel_pipeline_n && ctl.chip_sel_depth_hi
			&& !ctl.chip_sel_depth_lo_n;
		p_take = awake && !ctl.proc_addr_strobe_n
			&& !ctl.chip_sel_pipeline_n;
		c_take = awake && !p_take && !ctl.ctrl_addr_strobe_n;
		load   = p_take || c_take;
		desel  = load && !ce_ok;
		cont   = awake && !load && state_ff == PBSA_ST_ACTIVE;
	end

	// write detection and lane selection
	always_comb
	begin
		wr_det = !ctl.all_byte_write_n || !ctl.byte_write_gate_n;
		if (!ctl.all_byte_write_n)
			wr_mask = 4'hf;
		else if (!ctl.byte_write_gate_n)
			wr_mask = ~ctl.byte_lane_write_n;
		else
			wr_mask = 4'h0;
	end

	// access decision for this edge
	always_comb
	begin
		ctr_adv   = cont && !ctl.burst_advance_n;
		addr_used = {upper_ff, ctr_adv ? next_lo : cur_lo};
		if (load)
			addr_used = addr;
		wr_en     = (c_take && ce_ok && wr_det)
			|| (cont && wr_det);
		rd_issue  = (p_take && ce_ok)
			|| (c_take && ce_ok && !wr_det)
			|| (cont && !wr_det);
	end

	// next values of the access state
	always_comb
	begin
		nxt_state   = state_ff;
		nxt_upper   = upper_ff;
		nxt_rd_addr = rd_addr_ff;
		nxt_rd_pend = rd_issue;
		nxt_q_valid = rd_pend_ff && !wr_en && !desel && awake;
		nxt_mask    = rd_issue && load && state_ff != PBSA_ST_ACTIVE;
		nxt_dout    = dout_ff;
		if (rd_pend_ff)
			nxt_dout = mem_q[rd_addr_ff];
		if (rd_issue)
			nxt_rd_addr = addr_used;
		if (load && ce_ok)
			nxt_upper = addr[PBSA_AW-1:PBSA_UP_LSB];
		case (state_ff)
			PBSA_ST_IDLE:
			begin
				if (zz_s2_ff)
					nxt_state = PBSA_ST_SLEEP;
				else if (load && ce_ok)
					nxt_state = PBSA_ST_ACTIVE;
			end
			PBSA_ST_ACTIVE:
			begin
				if (zz_s2_ff)
					nxt_state = PBSA_ST_SLEEP;
				else if (desel)
					nxt_state = PBSA_ST_IDLE;
			end
			PBSA_ST_SLEEP:
			begin
				// a strobe on the edge the request clears starts an access
				if (!zz_s2_ff && load && ce_ok)
					nxt_state = PBSA_ST_ACTIVE;
				else if (!zz_s2_ff)
					nxt_state = PBSA_ST_IDLE;
			end
			default:
				nxt_state = PBSA_ST_IDLE;
		endcase
	end

	// access state registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_ff   <= PBSA_ST_IDLE;
			upper_ff   <= PBSA_UPPER_RST;
			rd_addr_ff <= PBSA_ADDR_RST;
			rd_pend_ff <= 1'h0;
			q_valid_ff <= 1'h0;
			mask_ff    <= 1'h0;
			dout_ff    <= PBSA_DOUT_RST;
		end
		else
		begin
			state_ff   <= nxt_state;
			upper_ff   <= nxt_upper;
			rd_addr_ff <= nxt_rd_addr;
			rd_pend_ff <= nxt_rd_pend;
			q_valid_ff <= nxt_q_valid;
			mask_ff    <= nxt_mask;
			dout_ff    <= nxt_dout;
		end
	end

	// array write, one lane per byte
	always_ff @(posedge clk)
	begin
		for (int i = 0; i < PBSA_LANES; i++)
		begin
			if (wr_en && wr_mask[i])
				mem_q[addr_used][8*i +: 8] <= data_in[8*i +: 8];
		end
	end

	// output drivers, gated asynchronously by output enable
	assign data_out = dout_ff;
	assign data_oe  = q_valid_ff && !output_drive_en_n
		&& !mask_ff
		&& !wr_en
		&& !zz_s2_ff;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_read_quiet;
		rd_issue ##1 (!wr_en && !desel && awake);
	endsequence

	sequence s_sleep_held;
		sleep_req [*3];
	endsequence

	a_read_latency: assert property (s_read_quiet |=> q_valid_ff)
		else $error("read data not valid one edge after issue");

	// output register is loaded one edge after the pending flag is set
	a_read_data: assert property (rd_issue |=> ##1
		(dout_ff == $past(mem_q[rd_addr_ff])))
		else $error("output register holds wrong location");

	a_desel_release: assert property (desel |=> !data_oe)
		else $error("data pins driven after deselect");

	a_write_release: assert property ((wr_det && awake && ctl.proc_addr_strobe_n
		&& (ctl.ctrl_addr_strobe_n ? state_ff == PBSA_ST_ACTIVE : ce_ok))
		|-> !data_oe)
		else $error("data pins driven during write cycle");

	a_first_mask: assert property ((rd_issue && load && state_ff != PBSA_ST_ACTIVE)
		|=> !data_oe)
		else $error("outputs not masked on first read clock");

	a_proc_write_wait: assert property ((p_take && ce_ok && wr_det) |-> !wr_en)
		else $error("processor strobe first cycle wrote the array");

	a_proc_gate: assert property ((ctl.chip_sel_pipeline_n && ctl.ctrl_addr_strobe_n)
		|-> !load)
		else $error("processor strobe taken with pipeline select high");

	a_addr_capture: assert property ((load && ce_ok) |=> (cur_lo == $past(addr[1:0])
		&& upper_ff == $past(addr[15:2])))
		else $error("address not captured on strobe");

	a_burst_step: assert property (ctr_adv |=> cur_lo == $past(next_lo))
		else $error("burst counter did not advance");

	a_burst_hold: assert property ((cont && ctl.burst_advance_n) |=> $stable(cur_lo))
		else $error("burst address moved without advance");

	a_global_lanes: assert property ((wr_en && !ctl.all_byte_write_n)
		|-> wr_mask == 4'hf)
		else $error("global write missed a lane");

	a_sleep_entry: assert property (s_sleep_held |=> state_ff == PBSA_ST_SLEEP)
		else $error("sleep not entered two cycles after request");

endmodule

// [dv/pbsa_host_model.sv]
// bus controller model driving the burst sram pins
`timescale 1ns/100ps
module pbsa_host_model
	import pbsa_pkg::*;
(
	// clock and device outputs
	input  wire logic        clk,
	input  wire logic [31:0] data_out,
	input  wire logic        data_oe,
	// bus toward the device
	output logic      [15:0] addr,
	output pbsa_ctrl_s       ctl,
	output logic      [31:0] data_in,
	output logic             output_drive_en_n,
	output logic             sleep_req,
	output logic             burst_order_sel
);
	logic [31:0] wd;

	// shared lines: device data, our data, or a changing pattern when released
	assign data_in = data_oe ? data_out : (output_drive_en_n ? wd : ~wd);

	// pin bundle from select flag, strobes/advance/write flags and lanes
	function automatic pbsa_ctrl_s k(input logic s, input logic [4:0] f, input logic [3:0] l);
		return {~s, s, ~s, f, l};
	endfunction

	// one bus cycle, pins changed just after the edge
	task automatic cy(input logic [15:0] a, input pbsa_ctrl_s c, input logic [31:0] d);
		addr = a;
		ctl = c;
		wd = d;
		output_drive_en_n = ~(c.all_byte_write_n & c.byte_write_gate_n);
		@(posedge clk);
		#1;
	endtask

	// idle pins at start
	initial
	begin
		addr = 16'h0;
		ctl = k(1'b0, 5'h1f, 4'hf);
		wd = 32'h0;
		output_drive_en_n = 1'b1;
		sleep_req = 1'b0;
		burst_order_sel = 1'b1;
	end
endmodule

// [dv/pipelined_burst_sram_access_tb_top.sv]
// self-checking bench for the burst sram access logic
`timescale 1ns/100ps
module pipelined_burst_sram_access_tb_top
	import pbsa_pkg::*;
;
	// strobe/advance/write flag sets: p, c, v, g, b
	localparam logic [4:0] IDL = 5'b11111;
	localparam logic [4:0] CRD = 5'b10111;
	localparam logic [4:0] CWR = 5'b10101;
	localparam logic [4:0] PST = 5'b01111;
	localparam logic [4:0] STP = 5'b11011;

	logic        clk;
	logic        rst;
	logic [15:0] addr;
	pbsa_ctrl_s  ctl;
	logic [31:0] data_in;
	logic [31:0] data_out;
	logic        data_oe;
	logic        oe_n;
	logic        sleep;
	logic        order;
	logic [31:0] q;
	int          fails;
	int          n_compared;

	pbsa_core dut (.clk(clk), .rst(rst), .addr(addr), .ctl(ctl), .data_in(data_in),
		.data_out(data_out), .data_oe(data_oe), .output_drive_en_n(oe_n),
		.sleep_req(sleep), .burst_order_sel(order));
	pbsa_host_model m (.clk(clk), .data_out(data_out), .data_oe(data_oe), .addr(addr),
		.ctl(ctl), .data_in(data_in), .output_drive_en_n(oe_n), .sleep_req(sleep),
		.burst_order_sel(order));

	// 50 ns clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// one cycle with all selects active
	task automatic go(input logic [15:0] a, input logic [4:0] f, input logic [31:0] d);
		m.cy(a, m.k(1'b1, f, 4'hf), d);
	endtask

	task automatic rd(input logic [15:0] a, output logic [31:0] v);
		go(a, CRD, 32'h0);
		go(a, IDL, 32'h0);
		v = data_out;
	endtask

	task automatic do_reset;
		rst = 1'b1;
		repeat (10) go(16'h0, IDL, 32'h0);
		rst = 1'b0;
		repeat (2) go(16'h0, IDL, 32'h0);
	endtask

	task automatic t_single;
		go(16'h0105, CWR, 32'hcafe0105);
		m.cy(16'h0, m.k(1'b0, CRD, 4'hf), 32'h0);
		go(16'h0105, CRD, 32'h0);
		chk({31'h0, data_oe}, 32'h0);
		go(16'h0, IDL, 32'h0);
		chk(data_out, 32'hcafe0105);
		chk({31'h0, data_oe}, 32'h1);
		go(16'h0, IDL, 32'h0);
		chk(data_out, 32'hcafe0105);
		m.output_drive_en_n = 1'b1;
		#1;
		chk({31'h0, data_oe}, 32'h0);
		@(posedge clk);
		#1;
		$display("single access done");
	endtask

	task automatic t_bytes;
		go(16'h0200, CWR, 32'hffffffff);
		go(16'h0200, 5'b00101, 32'h0); // both strobes, global write ignored
		m.cy(16'h0fff, m.k(1'b1, 5'b11110, 4'b1010), 32'h11223344);
		rd(16'h0200, q);
		chk(q, 32'hff22ff44);
		$display("byte write done");
	endtask

	task automatic t_burst;
		logic [1:0] e;
		for (int o = 1; o >= 0; o--)
		begin
			m.burst_order_sel = o[0];
			do_reset();
			for (int i = 0; i < 4; i++)
				go({14'h00c0, i[1:0]}, CWR, {30'h2fbbc000, i[1:0]});
			go(16'h0301, o[0] ? PST : CRD, 32'h0);
			for (int b = 0; b < 5; b++)
			begin
				go(16'hffff, STP, 32'h0);
				e = o[0] ? (2'h1 ^ b[1:0]) : 2'(1 + b);
				chk(data_out, {30'h2fbbc000, e});
			end
		end
		$display("burst orders done");
	endtask

	task automatic t_desel_sleep;
		rd(16'h0302, q);
		m.cy(16'h0302, m.k(1'b1, CRD, 4'hf) ^ 12'h400, 32'h0);
		chk({31'h0, data_oe}, 32'h0);
		m.sleep_req = 1'b1;
		repeat (4) go(16'h0, IDL, 32'h0);
		rd(16'h0302, q);
		chk({31'h0, data_oe}, 32'h0);
		m.sleep_req = 1'b0;
		repeat (PBSA_SLEEP_CYC) go(16'h0, IDL, 32'h0);
		rd(16'h0303, q);
		chk(q, 32'hbeef0003);
		$display("deselect and sleep done");
	endtask

	// main sequence
	initial
	begin
		rst = 1'b1;
		fails = 0;
		n_compared = 0;
		do_reset();
		t_single();
		t_bytes();
		t_burst();
		t_desel_sleep();
		stop_test();
	end

	// watchdog against a hang
	initial
	begin
		repeat (2000) @(posedge clk);
		fails++;
		$display("[ERR] %0t watchdog expired", $time);
		stop_test();
	end
endmodule
